/* spi_port_pkg.sv */
package spi_port_pkg;

    // ************************************************************
    // Register map, byte addresses on the bus.
    // ************************************************************
    localparam logic [31:0] ADDR_STATUS = 32'hffff0a00;
    localparam logic [31:0] ADDR_RECEIVE = 32'hffff0a04;
    localparam logic [31:0] ADDR_TRANSMIT = 32'hffff0a08;
    localparam logic [31:0] ADDR_DIVIDER = 32'hffff0a0c;
    localparam logic [31:0] ADDR_CONTROL = 32'hffff0a10;

    // ************************************************************
    // Control register fields.
    // ************************************************************
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_MASTER = 1;
    localparam int unsigned CTL_PHASE = 2;
    localparam int unsigned CTL_POLARITY = 3;
    localparam int unsigned CTL_LSB_FIRST = 5;
    localparam int unsigned CTL_TX_START = 6;
    localparam int unsigned CTL_UNDERFLOW_REPEAT = 7;
    localparam int unsigned CTL_OVERWRITE = 8;
    localparam int unsigned CTL_SS_OUT_EN = 9;
    localparam int unsigned CTL_SLAVE_OUT_EN = 10;
    localparam int unsigned CTL_LOOPBACK = 11;
    localparam int unsigned CTL_CONTINUOUS = 12;
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'h1fef;

    // ************************************************************
    // Status register fields.
    // ************************************************************
    localparam int unsigned STA_TX_BUSY = 0;
    localparam int unsigned STA_TX_IRQ = 1;
    localparam int unsigned STA_TX_UNDERFLOW = 2;
    localparam int unsigned STA_RX_FULL = 3;
    localparam int unsigned STA_RX_IRQ = 4;
    localparam int unsigned STA_RX_OVERFLOW = 5;

    // ************************************************************
    // Reset values and shift timing.
    // ************************************************************
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [7:0] DIVIDER_RESET = 8'h1b;
    localparam logic [7:0] RECEIVE_RESET = 8'h00;
    localparam logic [3:0] LAST_HALF_BIT = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_RUN = 3'b010,
        M_STALL = 3'b100
    } master_state_t;

endpackage

/* spi_port.sv */
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - With repeat mode clear, an underflowing byte is sent as all zeros.
// - Transmit-start mode set: transmit write starts master byte; interrupt on empty.
// - Transmit-start mode clear: receive read starts master byte; interrupt on full.
// - Bit-order bit set sends LSB first, clear sends MSB first.
// - Polarity bit set makes clock idle high, clear idle low.
// - Phase bit set pulses clock at bit start, clear at bit end.
// - Role bit set selects master, clear selects slave.
// - Port works only while its enable bit is set.
// - Byte arriving onto unread data sets overflow; receive read clears it.
// - Receive interrupt follows full or overflow; receive read clears it.
// - Receive full set while unread data is held; receive read clears it.
// - Underflow set when a byte is needed and none waits; transmit write clears.
// - Transmit interrupt when not busy or underflowed; cleared by write or disable.
// - Busy set by transmit write, held while shifting, cleared once empty.
// - Receive register is a read-only byte holding the last captured byte.
// - Transmit register is a write-only byte loading the next byte to send.
// - Divider register sets master clock rate and resets to 1b.
// - Master clock half period lasts divider plus one base clock cycles.
// - With repeat mode set, an underflowing byte repeats the previous byte.
// - Slave transfers run while select is low, eight bits per byte.
// - On overflow, overwrite bit set replaces unread byte, clear drops new byte.
module spi_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe
);
    import spi_port_pkg::*;

    // ************************************************************
    // Helpers shared by the transmit and receive shifters.
    // ************************************************************
    function automatic logic out_bit(input logic [7:0] b, input logic lsb);
        out_bit = lsb ? b[0] : b[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsb);
        shift_in = lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    // ************************************************************
    // State.
    // ************************************************************
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic [15:0] control_reg;
    logic [7:0] divider_reg;
    logic [7:0] rx_data_reg;
    logic rx_full_reg;
    logic rx_overflow_reg;
    logic rx_irq_reg;
    logic [7:0] tx_data_reg;
    logic tx_full_reg;
    logic tx_underflow_reg;
    logic tx_busy_reg;
    logic tx_irq_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] last_tx_reg;
    logic [7:0] rx_shift_reg;
    master_state_t state_reg;
    master_state_t state_next;
    logic [3:0] half_reg;
    logic [7:0] div_cnt_reg;
    logic start_pending_reg;
    logic [2:0] slave_cnt_reg;
    logic sclk_s1_reg, sclk_s2_reg, sclk_prev_reg;
    logic mosi_s1_reg, mosi_s2_reg;
    logic miso_s1_reg, miso_s2_reg;
    logic ss_n_s1_reg, ss_n_s2_reg;
    logic slave_act_prev_reg;
    logic sclk_out_reg, sclk_oe_reg, mosi_out_reg, mosi_oe_reg;
    logic miso_out_reg, miso_oe_reg, ss_n_out_reg, ss_n_oe_reg;

    // ************************************************************
    // Control decode.
    // ************************************************************
    wire enable = control_reg[CTL_ENABLE];
    wire master = control_reg[CTL_MASTER];
    wire phase = control_reg[CTL_PHASE];
    wire polarity = control_reg[CTL_POLARITY];
    wire lsb_first = control_reg[CTL_LSB_FIRST];
    wire tx_start_mode = control_reg[CTL_TX_START];
    wire repeat_mode = control_reg[CTL_UNDERFLOW_REPEAT];
    wire overwrite = control_reg[CTL_OVERWRITE];
    wire loopback = control_reg[CTL_LOOPBACK];
    wire continuous = control_reg[CTL_CONTINUOUS];
    wire master_on = enable & master;
    wire slave_on = enable & ~master;
    wire slave_active = slave_on & ~ss_n_s2_reg;

    // ************************************************************
    // Avalon-MM slave: one wait cycle, then the access completes.
    // ************************************************************
    wire request = avs_read | avs_write;
    wire accept = request & ~wait_reg;
    wire hit_status = avs_address == ADDR_STATUS;
    wire hit_receive = avs_address == ADDR_RECEIVE;
    wire hit_transmit = avs_address == ADDR_TRANSMIT;
    wire hit_divider = avs_address == ADDR_DIVIDER;
    wire hit_control = avs_address == ADDR_CONTROL;
    wire wr_accept = avs_write & accept;
    wire wr_control = wr_accept & hit_control;
    wire wr_divider = wr_accept & hit_divider & avs_byteenable[0];
    wire wr_transmit = wr_accept & hit_transmit & avs_byteenable[0];
    wire rx_read = avs_read & accept & hit_receive;
    wire [7:0] status_word = {2'b00, rx_overflow_reg, rx_irq_reg, rx_full_reg,
                              tx_underflow_reg, tx_irq_reg, tx_busy_reg};
    wire [15:0] control_merged = {avs_byteenable[1] ? avs_writedata[15:8] : control_reg[15:8],
                                  avs_byteenable[0] ? avs_writedata[7:0] : control_reg[7:0]};
    wire [31:0] readdata_next = hit_status ? {24'h000000, status_word} :
                                hit_receive ? {24'h000000, rx_data_reg} :
                                hit_divider ? {24'h000000, divider_reg} :
                                hit_control ? {16'h0000, control_reg} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (reset) begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= ~(request & wait_reg);
            if (avs_read & wait_reg) begin
                readdata_reg <= readdata_next;
            end
        end
    end

    // Bit 4 and the top three bits are never stored, so a stray one reads back as zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            control_reg <= CONTROL_RESET;
            divider_reg <= DIVIDER_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= control_merged & CONTROL_WRITE_MASK;
            end
            if (wr_divider) begin
                divider_reg <= avs_writedata[7:0];
            end
        end
    end

    // ************************************************************
    // Pin synchronisers.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            {sclk_s1_reg, sclk_s2_reg, sclk_prev_reg, mosi_s1_reg, mosi_s2_reg} <= 5'h00;
            {miso_s1_reg, miso_s2_reg, ss_n_s1_reg, ss_n_s2_reg, slave_act_prev_reg} <= 5'h06;
        end else begin
            sclk_s1_reg <= sclk_in;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_prev_reg <= sclk_s2_reg;
            mosi_s1_reg <= mosi_in;
            mosi_s2_reg <= mosi_s1_reg;
            miso_s1_reg <= miso_in;
            miso_s2_reg <= miso_s1_reg;
            ss_n_s1_reg <= ss_n_in;
            ss_n_s2_reg <= ss_n_s1_reg;
            slave_act_prev_reg <= slave_active;
        end
    end

    // ************************************************************
    // Master sequencer: sixteen half bits per byte.
    // ************************************************************
    wire tick = div_cnt_reg == divider_reg;
    wire running = state_reg == M_RUN;
    wire first_half = ~half_reg[0];
    wire tx_avail = tx_full_reg | wr_transmit;
    wire start_cond = tx_start_mode ? tx_full_reg : start_pending_reg;
    wire m_start = (state_reg == M_IDLE) & master_on & start_cond;
    wire m_sample = running & tick & first_half;
    wire m_done = running & tick & (half_reg == LAST_HALF_BIT);
    wire m_shift = running & tick & ~first_half & ~m_done;
    wire m_chain = m_done & continuous & tx_start_mode & tx_full_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            M_IDLE: begin
                if (m_start) begin
                    state_next = M_RUN;
                end
            end
            M_RUN: begin
                if (!master_on) begin
                    state_next = M_IDLE;
                end else if (m_done && !m_chain) begin
                    state_next = M_STALL;
                end
            end
            M_STALL: begin
                if (!master_on || tick) begin
                    state_next = M_IDLE;
                end
            end
            default: begin
                state_next = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= M_IDLE;
            half_reg <= 4'h0;
            div_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == M_IDLE || tick) begin
                div_cnt_reg <= 8'h00;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
            if (m_start || m_chain) begin
                half_reg <= 4'h0;
            end else if (running && tick) begin
                half_reg <= half_reg + 4'h1;
            end
        end
    end

    // A receive read in read-start mode is remembered until the master takes it.
    always_ff @(posedge clk) begin
        if (reset) begin
            start_pending_reg <= 1'b0;
        end else if (!master_on || tx_start_mode) begin
            start_pending_reg <= 1'b0;
        end else if (rx_read) begin
            start_pending_reg <= 1'b1;
        end else if (m_start) begin
            start_pending_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Slave sequencer, driven by the synchronised serial clock.
    // ************************************************************
    wire lead_edge = (sclk_s2_reg != polarity) & (sclk_prev_reg == polarity);
    wire trail_edge = (sclk_s2_reg == polarity) & (sclk_prev_reg != polarity);
    wire s_sample = slave_active & (phase ? trail_edge : lead_edge);
    wire s_done = s_sample & (slave_cnt_reg == LAST_BIT);
    wire s_shift = slave_active & (phase ? lead_edge : trail_edge) & (slave_cnt_reg != 3'h0);
    wire s_start = slave_active & ~slave_act_prev_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            slave_cnt_reg <= 3'h0;
        end else if (!slave_active) begin
            slave_cnt_reg <= 3'h0;
        end else if (s_sample) begin
            slave_cnt_reg <= slave_cnt_reg + 3'h1;
        end
    end

    // ************************************************************
    // Shifters and transmit holding register.
    // ************************************************************
    wire load_byte = m_start | m_chain | s_start | s_done;
    wire shift_now = m_shift | s_shift;
    wire sample_now = m_sample | s_sample;
    wire rx_pin = master ? (loopback ? mosi_out_reg : miso_s2_reg)
                         : (loopback ? miso_out_reg : mosi_s2_reg);
    wire [7:0] rx_assembled = shift_in(rx_shift_reg, rx_pin, lsb_first);
    wire [7:0] rx_byte = s_done ? rx_assembled : rx_shift_reg;
    wire byte_done = m_done | s_done;
    wire [7:0] tx_source = tx_full_reg ? tx_data_reg : avs_writedata[7:0];
    wire [7:0] underflow_byte = repeat_mode ? last_tx_reg : 8'h00;
    wire busy_now = tx_full_reg | running | slave_active;

    always_ff @(posedge clk) begin
        if (reset) begin
            {tx_shift_reg, last_tx_reg, rx_shift_reg} <= 24'h000000;
        end else begin
            if (load_byte) begin
                tx_shift_reg <= tx_avail ? tx_source : underflow_byte;
                if (tx_avail) begin
                    last_tx_reg <= tx_source;
                end
            end else if (shift_now) begin
                tx_shift_reg <= shift_in(tx_shift_reg, 1'b0, lsb_first);
            end
            if (sample_now) begin
                rx_shift_reg <= rx_assembled;
            end
        end
    end

    // A write landing on the load cycle is either queued or sent at once, never lost.
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_data_reg <= 8'h00;
            {tx_full_reg, tx_underflow_reg, tx_busy_reg, tx_irq_reg} <= 4'h0;
        end else begin
            if (wr_transmit) begin
                tx_data_reg <= avs_writedata[7:0];
            end
            if (load_byte) begin
                tx_full_reg <= tx_full_reg & wr_transmit;
            end else begin
                tx_full_reg <= tx_full_reg | wr_transmit;
            end
            if (load_byte && !tx_avail) begin
                tx_underflow_reg <= 1'b1;
            end else if (wr_transmit) begin
                tx_underflow_reg <= 1'b0;
            end
            tx_busy_reg <= busy_now | wr_transmit;
            tx_irq_reg <= enable & ~wr_transmit & (~busy_now | tx_underflow_reg);
        end
    end

    // ************************************************************
    // Receive holding register and its flags.
    // ************************************************************
    wire rx_held = rx_full_reg & ~rx_read;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_data_reg <= RECEIVE_RESET;
            {rx_full_reg, rx_overflow_reg, rx_irq_reg} <= 3'h0;
        end else begin
            if (byte_done) begin
                if (!rx_held || overwrite) begin
                    rx_data_reg <= rx_byte;
                end
                rx_full_reg <= 1'b1;
                rx_overflow_reg <= rx_held | (rx_overflow_reg & ~rx_read);
                rx_irq_reg <= 1'b1;
            end else if (rx_read) begin
                rx_full_reg <= 1'b0;
                rx_overflow_reg <= 1'b0;
                rx_irq_reg <= 1'b0;
            end else begin
                rx_irq_reg <= rx_full_reg | rx_overflow_reg;
            end
        end
    end

    // ************************************************************
    // Registered pin drivers.
    // ************************************************************
    wire clk_active = running & (phase ? first_half : ~first_half);

    always_ff @(posedge clk) begin
        if (reset) begin
            {sclk_out_reg, sclk_oe_reg, mosi_out_reg, mosi_oe_reg} <= 4'h0;
            {miso_out_reg, miso_oe_reg, ss_n_out_reg, ss_n_oe_reg} <= 4'h2;
        end else begin
            sclk_out_reg <= polarity ^ clk_active;
            sclk_oe_reg <= master_on;
            mosi_out_reg <= out_bit(tx_shift_reg, lsb_first);
            mosi_oe_reg <= master_on;
            miso_out_reg <= out_bit(tx_shift_reg, lsb_first);
            miso_oe_reg <= slave_active & control_reg[CTL_SLAVE_OUT_EN];
            ss_n_out_reg <= ~running;
            ss_n_oe_reg <= master_on & control_reg[CTL_SS_OUT_EN];
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = wait_reg;
    assign sclk_out = sclk_out_reg;
    assign sclk_oe = sclk_oe_reg;
    assign mosi_out = mosi_out_reg;
    assign mosi_oe = mosi_oe_reg;
    assign miso_out = miso_out_reg;
    assign miso_oe = miso_oe_reg;
    assign ss_n_out = ss_n_out_reg;
    assign ss_n_oe = ss_n_oe_reg;

endmodule

`default_nettype wire

/* spi_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Bus handshake, register and serial clock checks.
// ****
module spi_port_checks
    import spi_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic ss_n_out,
    input wire logic miso_oe
);
    logic [7:0] div_reg;
    logic [8:0] gap;
    logic seen;
    logic rd_done;
    assign rd_done = avs_read && !avs_waitrequest;
    // Shadow of the divider and the spacing of clock edges inside a frame.
    always_ff @(posedge clk) begin
        if (reset) begin
            div_reg <= DIVIDER_RESET;
            gap <= 9'h000;
            seen <= 1'b0;
        end else begin
            if (avs_write && !avs_waitrequest && avs_address == ADDR_DIVIDER) begin
                div_reg <= avs_writedata[7:0];
            end
            gap <= $changed(sclk_out) ? 9'h001 : gap + 9'h001;
            seen <= !ss_n_out && ($changed(sclk_out) || seen);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("waitrequest held too long");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
    chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest low without request");
    chk_status_zero: assert property (rd_done && avs_address == ADDR_STATUS
        |-> avs_readdata[31:6] == 26'h0) else $error("status high bits set");
    chk_tx_zero: assert property (rd_done && avs_address == ADDR_TRANSMIT
        |-> avs_readdata == 32'h0) else $error("transmit read not zero");
    chk_div_value: assert property (rd_done && avs_address == ADDR_DIVIDER
        |-> avs_readdata == {24'h0, div_reg}) else $error("divider value wrong");
    chk_sclk_rate: assert property ($changed(sclk_out) && seen && !ss_n_out
        |-> gap == {1'b0, div_reg} + 9'h001) else $error("clock half period wrong");
    chk_one_role: assert property (!(sclk_oe && miso_oe))
        else $error("master and slave drivers both on");
endmodule
bind spi_port spi_port_checks u_spi_port_checks (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .ss_n_out(ss_n_out), .miso_oe(miso_oe));
`default_nettype wire

/* spi_far_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Far side slave: answers a fixed byte and captures what it is sent.
// ****
module spi_far_slave (
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    int n = 0;
    initial miso = 1'b0;
    initial got = 8'h00;
    always @(negedge ss_n) begin
        n = 0;
        // The first bit stands as select falls, so a clock edge in the same step cannot race it.
        miso = reply[7];
    end
    // A released line shows the inverse of its last value.
    always @(posedge ss_n) miso = ~miso;
    always @(sclk) begin
        if (!ss_n && ((sclk != cpol) != cpha)) begin
            got = {got[6:0], mosi};
            n = n + 1;
        end else if (!ss_n && n < 8) begin
            miso = reply[7 - n];
        end
    end
endmodule
`default_nettype wire

/* spi_master_slave_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Register level tests of the serial port in master and slave mode.
// ****
module spi_master_slave_port_test;
    import spi_port_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] avs_address = 32'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, sclk_out, sclk_oe, mosi_out, ss_n_out, miso_in, miso_out, miso_oe;
    logic sclk_in = 1'b0, mosi_in = 1'b0, ss_n_in = 1'b1;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic [7:0] reply = 8'h00;
    logic [7:0] got, tx, s_got;
    logic [31:0] q;
    int fail_count = 0;
    int checks = 0;
    spi_port u_spi_port (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(),
        .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
        .ss_n_out(ss_n_out), .ss_n_oe());
    spi_far_slave u_spi_far_slave (.ss_n(ss_n_out), .sclk(sclk_out), .mosi(mosi_out),
        .cpol(cpol), .cpha(cpha), .reply(reply), .miso(miso_in), .got(got));
    initial forever #50 clk = ~clk;
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        check(s, e, q);
    endtask
    // A read-started byte shows busy only two edges after its start, so polling waits first.
    task automatic wait_idle;
        repeat (2) @(posedge clk);
        do begin
            bus(1'b0, ADDR_STATUS, 32'h0);
        end while (q[STA_TX_BUSY] !== 1'b0);
    endtask
    task automatic complete_run;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_STATUS, 32'h0, "status");
        rd(ADDR_RECEIVE, 32'h0, "receive");
        rd(ADDR_DIVIDER, 32'h1b, "divider");
        rd(ADDR_TRANSMIT, 32'h0, "transmit");
        rd(32'hffff0a14, 32'h0, "unmapped");
        bus(1'b1, ADDR_CONTROL, 32'he000);
        rd(ADDR_CONTROL, 32'h0, "control");
        bus(1'b1, ADDR_DIVIDER, 32'h3);
        rd(ADDR_DIVIDER, 32'h3, "divider");
        for (int m = 0; m < 8; m++) begin
            cpha = m[0];
            cpol = m[1];
            bus(1'b1, ADDR_CONTROL, {26'h1, m[2], 1'b0, m[1], m[0], 2'b11});
            repeat (2) @(posedge clk);
            check("sclk idle", {31'h0, m[1]}, {31'h0, sclk_out});
            tx = 8'h31 + 8'(m * 17);
            reply = 8'hc4 ^ 8'(m);
            bus(1'b1, ADDR_TRANSMIT, {24'h0, tx});
            bus(1'b0, ADDR_STATUS, 32'h0);
            check("busy", 32'h1, {31'h0, q[0]});
            wait_idle;
            check("sent", {24'h0, m[2] ? rev(tx) : tx}, {24'h0, got});
            rd(ADDR_STATUS, 32'h1a, "status");
            rd(ADDR_RECEIVE, {24'h0, m[2] ? rev(reply) : reply}, "receive");
            rd(ADDR_STATUS, 32'h02, "status");
        end
        cpha = 1'b0;
        cpol = 1'b0;
        for (int ov = 0; ov < 2; ov++) begin
            bus(1'b1, ADDR_CONTROL, {23'h0, ov[0], 8'h43});
            reply = 8'h81;
            bus(1'b1, ADDR_TRANSMIT, 32'h3c);
            wait_idle;
            reply = 8'h7e;
            bus(1'b1, ADDR_TRANSMIT, 32'h3c);
            wait_idle;
            rd(ADDR_STATUS, 32'h3a, "overflow");
            rd(ADDR_RECEIVE, ov ? 32'h7e : 32'h81, "receive");
            rd(ADDR_STATUS, 32'h02, "status");
        end
        bus(1'b1, ADDR_CONTROL, 32'h83);
        bus(1'b0, ADDR_RECEIVE, 32'h0);
        wait_idle;
        check("repeat", 32'h3c, {24'h0, got});
        rd(ADDR_STATUS, 32'h1e, "underflow");
        bus(1'b1, ADDR_CONTROL, 32'h03);
        bus(1'b0, ADDR_RECEIVE, 32'h0);
        wait_idle;
        check("zeros", 32'h0, {24'h0, got});
        rd(ADDR_STATUS, 32'h1e, "underflow");
        bus(1'b1, ADDR_TRANSMIT, 32'h55);
        rd(ADDR_STATUS, 32'h19, "tx write");
        bus(1'b1, ADDR_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        check("sclk oe", 32'h0, {31'h0, sclk_oe});
        check("select", 32'h1, {31'h0, ss_n_out});
        rd(ADDR_STATUS, 32'h19, "disabled");
        tx = 8'ha5;
        bus(1'b1, ADDR_CONTROL, 32'h0501);
        ss_n_in <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            mosi_in <= tx[b];
            repeat (6) @(posedge clk);
            sclk_in <= 1'b1;
            s_got = {s_got[6:0], miso_out};
            repeat (6) @(posedge clk);
            sclk_in <= 1'b0;
        end
        repeat (6) @(posedge clk);
        check("miso oe", 32'h1, {31'h0, miso_oe});
        ss_n_in <= 1'b1;
        check("slave tx", 32'h55, {24'h0, s_got});
        repeat (6) @(posedge clk);
        rd(ADDR_RECEIVE, 32'ha5, "slave rx");
        complete_run;
    end
endmodule
`default_nettype wire
